// File: istx_params.svh
`ifndef ISTX_PARAMS_SVH
`define ISTX_PARAMS_SVH

// Register offsets on the plain register port
`define ISTX_ADDR_W      12
`define ISTX_OFS_DATA    12'hF50
`define ISTX_OFS_ISTAT   12'hF51
`define ISTX_OFS_CTL     12'hF52
`define ISTX_OFS_MODE    12'hF53
`define ISTX_OFS_SLVAD   12'hF54

// Interrupt status bit positions
`define ISTX_IS_TXE      7
`define ISTX_IS_RXF      6
`define ISTX_IS_AM       5
`define ISTX_IS_GCA      4
`define ISTX_IS_RD       3
`define ISTX_IS_STOP_RESTART_FLAG     1
`define ISTX_IS_NAK      0

// Control and mode bit positions
`define ISTX_CTL_EN      7
`define ISTX_CTL_TXI     6
`define ISTX_CTL_FLUSH   1
`define ISTX_CTL_NAK     0
`define ISTX_MODE_GCE    2
`define ISTX_MODE_SLA9   1
`define ISTX_MODE_SLA8   0

// Address byte constants, data reset value and bit counter values
`define ISTX_PREFIX      5'h1E
`define ISTX_GC_ADDR     8'h00
`define ISTX_DATA_RST    8'h00
`define ISTX_BITS        4'h8
`define ISTX_ACK_SEEN    4'h9

`endif

// File: istx_pkg.sv
package istx_pkg;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_ADDR    = 7'h02,
    ST_ACK_OUT = 7'h04,
    ST_RX      = 7'h08,
    ST_TX_LOAD = 7'h10,
    ST_TX      = 7'h20,
    ST_ACK_IN  = 7'h40
  } istx_st_t;

  typedef struct packed {
    istx_st_t    st;
    istx_st_t    nxt;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  data;
    logic [7:0]  rdata;
    logic [9:0]  own_slave_address;
    logic        te;
    logic        rf;
    logic        am;
    logic        gca;
    logic        rd;
    logic        nk;
    logic        sp;
    logic        en;
    logic        txie;
    logic        nak;
    logic        general_call_enable;
    logic        phase2;
    logic        hi_ok;
    logic        active;
    logic        rx_mode;
    logic        sda_oe;
    logic        scl_oe;
  } istx_core_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } istx_sync_t;

endpackage

// File: istx_sync.sv
`timescale 1ns/10ps
module istx_sync
  import istx_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] pin_i,
  output logic      [1:0] lvl_o,
  output logic      [1:0] rise_o,
  output logic      [1:0] fall_o
);

  istx_sync_t q;
  istx_sync_t d;

  always_comb begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  // Lines idle high, so the chain resets to ones
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign lvl_o  = q.s2;
  assign rise_o = q.s2 & ~q.s3;
  assign fall_o = ~q.s2 & q.s3;

endmodule // istx_sync

// File: istx_core.sv
// Overview of operation
// - Ack first address byte whose prefix matches upper address bits, write.
// - Second byte matching lower address sets match flag, clears read bit.
// - Acknowledge second address byte only when it matches lower address.
// - Reading interrupt status clears the address-match flag.
// - Restart plus matching read prefix sets match, read bit, and acks.
// - Hold SCL low at data start until a transmit byte is available.
// - Set transmit-empty once first bit of a data byte is on the bus.
// - Stretch SCL before the MSB when no next byte has been written.
// - Not-acknowledge after a transmitted byte sets the not-ack flag.
// - Stop or restart ending our transaction sets stop/restart flag.
// - Reading interrupt status clears the stop/restart flag.
// - Data register feeds and receives the hidden shift register.
// - Software data writes are ignored while receiving as a slave.
// - Writing the data register clears transmit-empty.
// - Reading the data register clears receive-full.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "istx_params.svh"
module istx_core
  import istx_pkg::*;
(
  input  wire logic                    CLK_I,
  input  wire logic                    RSTN_I,
  input  wire logic [`ISTX_ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]              WDATA_I,
  input  wire logic                    WR_I,
  input  wire logic                    RD_I,
  output logic      [7:0]              RDATA_O,
  input  wire logic                    SCL_I,
  output logic                         SCL_O,
  output logic                         SCL_OE_O,
  input  wire logic                    SDA_I,
  output logic                         SDA_O,
  output logic                         SDA_OE_O
);

  localparam istx_core_t RST = '{st: ST_IDLE, nxt: ST_IDLE, te: 1'b1,
                                 data: `ISTX_DATA_RST, default: '0};

  istx_core_t q;
  istx_core_t d;
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda;
  logic       start_c;
  logic       stop_c;
  logic       hi_hit;
  logic       lo_hit;
  logic       gc_hit;
  logic       byte_end;
  logic       set_am;
  logic       set_sp;
  logic       set_nk;
  logic       set_te;
  logic       set_rf;
  logic [7:0] rv;

  istx_sync u_sync (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .pin_i  ({SDA_I, SCL_I}),
    .lvl_o  (lvl),
    .rise_o (rise),
    .fall_o (fall)
  );

  assign scl_rise = rise[0];
  assign scl_fall = fall[0];
  assign sda      = lvl[1];
  assign start_c  = fall[1] & lvl[0];
  assign stop_c   = rise[1] & lvl[0];
  assign hi_hit   = (q.shreg[7:3] == `ISTX_PREFIX) &&
                    (q.shreg[2:1] == q.own_slave_address[9:8]);
  assign lo_hit   = (q.shreg == q.own_slave_address[7:0]);
  assign gc_hit   = q.general_call_enable && (q.shreg == `ISTX_GC_ADDR);
  assign byte_end = scl_fall && (q.bitcnt == `ISTX_BITS);

  always_comb begin
    d      = q;
    set_am = 1'b0;
    set_sp = 1'b0;
    set_nk = 1'b0;
    set_te = 1'b0;
    set_rf = 1'b0;
    rv     = 8'h00;

    // Register read mux, data stands in the following cycle
    case (ADDR_I)
      `ISTX_OFS_DATA:  rv = q.data;
      `ISTX_OFS_ISTAT: begin
        rv[`ISTX_IS_TXE]  = q.te;
        rv[`ISTX_IS_RXF]  = q.rf;
        rv[`ISTX_IS_AM]   = q.am;
        rv[`ISTX_IS_GCA]  = q.gca;
        rv[`ISTX_IS_RD]   = q.rd;
        rv[`ISTX_IS_STOP_RESTART_FLAG] = q.sp;
        rv[`ISTX_IS_NAK]  = q.nk;
      end
      `ISTX_OFS_CTL: begin
        rv[`ISTX_CTL_EN]  = q.en;
        rv[`ISTX_CTL_TXI] = q.txie;
        rv[`ISTX_CTL_NAK] = q.nak;
      end
      `ISTX_OFS_MODE: begin
        rv[`ISTX_MODE_GCE]  = q.general_call_enable;
        rv[`ISTX_MODE_SLA9] = q.own_slave_address[9];
        rv[`ISTX_MODE_SLA8] = q.own_slave_address[8];
      end
      `ISTX_OFS_SLVAD: rv = q.own_slave_address[7:0];
      default:         rv = 8'h00;
    endcase
    d.rdata = RD_I ? rv : 8'h00;

    // Read side effects
    if (RD_I && ADDR_I == `ISTX_OFS_ISTAT) begin
      d.am = 1'b0;
      d.sp = 1'b0;
      d.nk = 1'b0;
    end
    if (RD_I && ADDR_I == `ISTX_OFS_DATA) begin
      d.rf = 1'b0;
    end

    // Register writes
    if (WR_I) begin
      case (ADDR_I)
        `ISTX_OFS_DATA: begin
          if (!q.rx_mode) begin
            d.data = WDATA_I;
            d.te   = 1'b0;
          end
        end
        `ISTX_OFS_CTL: begin
          d.en   = WDATA_I[`ISTX_CTL_EN];
          d.txie = WDATA_I[`ISTX_CTL_TXI];
          d.nak  = WDATA_I[`ISTX_CTL_NAK];
          if (WDATA_I[`ISTX_CTL_FLUSH]) begin
            d.te = 1'b1;
          end
        end
        `ISTX_OFS_MODE: begin
          d.general_call_enable    = WDATA_I[`ISTX_MODE_GCE];
          d.own_slave_address[9] = WDATA_I[`ISTX_MODE_SLA9];
          d.own_slave_address[8] = WDATA_I[`ISTX_MODE_SLA8];
        end
        `ISTX_OFS_SLVAD: d.own_slave_address[7:0] = WDATA_I;
        default: ;
      endcase
    end

    // Bus engine
    if (!q.en) begin
      d.st      = ST_IDLE;
      d.rd      = 1'b0;
      d.gca     = 1'b0;
      d.sda_oe  = 1'b0;
      d.scl_oe  = 1'b0;
      d.active  = 1'b0;
      d.hi_ok   = 1'b0;
      d.rx_mode = 1'b0;
      d.phase2  = 1'b0;
    end else if (start_c) begin
      set_sp    = q.active;
      d.st      = ST_ADDR;
      d.bitcnt  = 4'h0;
      d.sda_oe  = 1'b0;
      d.scl_oe  = 1'b0;
      d.phase2  = 1'b0;
      d.active  = 1'b0;
      d.rx_mode = 1'b0;
    end else if (stop_c) begin
      set_sp    = q.active;
      d.st      = ST_IDLE;
      d.sda_oe  = 1'b0;
      d.scl_oe  = 1'b0;
      d.hi_ok   = 1'b0;
      d.active  = 1'b0;
      d.rx_mode = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: ;
        ST_ADDR, ST_RX: begin
          if (scl_rise && q.bitcnt < `ISTX_BITS) begin
            d.shreg  = {q.shreg[6:0], sda};
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (byte_end) begin
            d.bitcnt = 4'h0;
            if (q.st == ST_RX) begin
              set_rf   = 1'b1;
              d.data   = q.shreg;
              d.sda_oe = !q.nak;
              d.nxt    = ST_RX;
              d.st     = ST_ACK_OUT;
            end else if (!q.phase2) begin
              if (hi_hit && !q.shreg[0]) begin
                d.sda_oe = 1'b1;
                d.phase2 = 1'b1;
                d.active = 1'b1;
                d.nxt    = ST_ADDR;
                d.st     = ST_ACK_OUT;
              end else if (hi_hit && q.hi_ok) begin
                set_am   = 1'b1;
                d.rd     = 1'b1;
                d.gca    = 1'b0;
                d.sda_oe = 1'b1;
                d.active = 1'b1;
                d.nxt    = ST_TX_LOAD;
                d.st     = ST_ACK_OUT;
              end else if (gc_hit) begin
                set_am    = 1'b1;
                d.rd      = 1'b0;
                d.gca     = 1'b1;
                d.sda_oe  = 1'b1;
                d.active  = 1'b1;
                d.rx_mode = 1'b1;
                d.nxt     = ST_RX;
                d.st      = ST_ACK_OUT;
              end else begin
                d.hi_ok = 1'b0;
                d.st    = ST_IDLE;
              end
            end else if (lo_hit) begin
              set_am    = 1'b1;
              d.rd      = 1'b0;
              d.gca     = 1'b0;
              d.hi_ok   = 1'b1;
              d.sda_oe  = 1'b1;
              d.rx_mode = 1'b1;
              d.nxt     = ST_RX;
              d.st      = ST_ACK_OUT;
            end else begin
              d.hi_ok  = 1'b0;
              d.active = 1'b0;
              d.st     = ST_IDLE;
            end
          end
        end
        ST_ACK_OUT: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 4'h0;
            d.st     = q.nxt;
          end
        end
        ST_TX_LOAD: begin
          d.scl_oe = q.te || q.scl_oe;
          if (!q.te) begin
            d.shreg  = q.data;
            d.sda_oe = !q.data[7];
            d.bitcnt = 4'h0;
            d.st     = ST_TX;
          end
        end
        ST_TX: begin
          d.scl_oe = 1'b0;
          if (scl_rise) begin
            d.bitcnt = q.bitcnt + 4'h1;
            set_te   = (q.bitcnt == 4'h0);
          end
          if (byte_end) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 4'h0;
            d.st     = ST_ACK_IN;
          end else if (scl_fall) begin
            d.shreg  = {q.shreg[6:0], 1'b0};
            d.sda_oe = !q.shreg[6];
          end
        end
        ST_ACK_IN: begin
          if (scl_rise) begin
            if (sda) begin
              set_nk = 1'b1;
              d.st   = ST_IDLE;
            end else begin
              d.bitcnt = `ISTX_ACK_SEEN;
            end
          end
          if (scl_fall && q.bitcnt == `ISTX_ACK_SEEN) begin
            d.bitcnt = 4'h0;
            d.st     = ST_TX_LOAD;
          end
        end
        default: d.st = ST_IDLE;
      endcase
    end

    // Hardware sets win over same-cycle clears
    if (set_am) d.am = 1'b1;
    if (set_sp) d.sp = 1'b1;
    if (set_nk) d.nk = 1'b1;
    if (set_te) d.te = 1'b1;
    if (set_rf) d.rf = 1'b1;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign RDATA_O  = q.rdata;
  assign SCL_O    = 1'b0;
  assign SDA_O    = 1'b0;
  assign SCL_OE_O = q.scl_oe;
  assign SDA_OE_O = q.sda_oe;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  chk_istat_clr: assert property (
    (RD_I && ADDR_I == `ISTX_OFS_ISTAT && !set_am && !set_sp)
      |=> (!q.am && !q.sp))
    else $error("status read did not clear match or stop flag");

  chk_txe_wr_clr: assert property (
    (WR_I && ADDR_I == `ISTX_OFS_DATA && !q.rx_mode && !set_te)
      |=> !q.te)
    else $error("data write did not clear transmit empty");

  chk_rxf_rd_clr: assert property (
    (RD_I && ADDR_I == `ISTX_OFS_DATA && !set_rf) |=> !q.rf)
    else $error("data read did not clear receive full");

  chk_wr_blocked: assert property (
    (WR_I && ADDR_I == `ISTX_OFS_DATA && q.rx_mode && !set_rf)
      |=> $stable(q.data))
    else $error("data write accepted during slave receive");

  chk_scl_stretch: assert property (
    (q.st == ST_TX_LOAD && q.te && q.en && !start_c && !stop_c)
      |=> SCL_OE_O && q.st == ST_TX_LOAD)
    else $error("SCL not held while no byte is loaded");

  chk_txe_first: assert property (
    (q.st == ST_TX && scl_rise && q.bitcnt == 4'h0 && q.en)
      |=> q.te)
    else $error("transmit empty not set after first bit");

  chk_nak_flag: assert property (
    (q.st == ST_ACK_IN && scl_rise && sda && q.en && !start_c && !stop_c)
      |=> q.nk ##1 q.st == ST_IDLE || q.st == ST_ADDR)
    else $error("not acknowledge not flagged");

  chk_stop_flag: assert property (
    ((start_c || stop_c) && q.active && q.en) |=> q.sp)
    else $error("stop or restart not flagged");

  chk_lo_match: assert property (
    (q.st == ST_ADDR && q.phase2 && byte_end && lo_hit && q.en
     && !start_c && !stop_c)
      |=> (q.am && !q.rd && SDA_OE_O && q.st == ST_ACK_OUT))
    else $error("second address byte match not handled");

  chk_rd_match: assert property (
    (q.st == ST_ADDR && !q.phase2 && byte_end && hi_hit && q.shreg[0]
     && q.hi_ok && q.en && !start_c && !stop_c)
      |=> (q.am && q.rd && SDA_OE_O && q.nxt == ST_TX_LOAD))
    else $error("read prefix after restart not handled");

endmodule // istx_core

// File: istx_i2c_master.sv
`timescale 1ns/10ps
// Bus master: 800 ns bit period, open drain, honours clock stretching
module istx_i2c_master (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic scl_i,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Data settles in the low phase; slave answers within about 300 ns after a fall
  task automatic bitx(input logic b, output logic r);
    #100 sda_o = b;
    #400 scl_o = 1'b1;
    for (int i = 0; i < 2000 && scl_i !== 1'b1; i++) #10;
    #300 r = sda_i;
    scl_o = 1'b0;
  endtask

  // Also serves as the repeated start
  task automatic start();
    #100 sda_o = 1'b1;
    #400 scl_o = 1'b1;
    #400 sda_o = 1'b0;
    #400 scl_o = 1'b0;
  endtask

  task automatic stop();
    #100 sda_o = 1'b0;
    #400 scl_o = 1'b1;
    #400 sda_o = 1'b1;
    #400;
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(nak, r);
  endtask
endmodule // istx_i2c_master

// File: tb_top.sv
`timescale 1ns/10ps
`include "istx_params.svh"
module tb_top;
  typedef struct packed {
    logic [11:0] a;
    logic        w;
    logic [7:0]  d;
    logic [7:0]  e;
  } istx_row_t;

  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       scl_oe;
  logic       sda_oe;
  logic       scl_o;
  logic       sda_o;
  logic       m_scl;
  logic       m_sda;
  logic [7:0] d0;
  logic [7:0] d1;
  logic [7:0] rv;
  int         err_count = 0;
  int         compares = 0;
  wire        scl_w = m_scl & (scl_oe ? scl_o : 1'b1);
  wire        sda_w = m_sda & (sda_oe ? sda_o : 1'b1);

  istx_row_t rows [9] = '{
    {`ISTX_OFS_DATA, 1'b0, 8'h00, 8'h00},
    {`ISTX_OFS_ISTAT, 1'b0, 8'h00, 8'h80},
    {`ISTX_OFS_DATA, 1'b1, 8'hA5, 8'hA5},
    {`ISTX_OFS_ISTAT, 1'b0, 8'h00, 8'h00},
    {`ISTX_OFS_SLVAD, 1'b1, 8'h5C, 8'h5C},
    {`ISTX_OFS_MODE, 1'b1, 8'h02, 8'h02},
    {12'hF7F, 1'b1, 8'hFF, 8'h00},
    {`ISTX_OFS_CTL, 1'b1, 8'h02, 8'h00},
    {`ISTX_OFS_ISTAT, 1'b0, 8'h00, 8'h80}
  };

  always #50 clk = ~clk;

  istx_core u_dut (
    .CLK_I    (clk),
    .RSTN_I   (rstn),
    .ADDR_I   (addr),
    .WDATA_I  (wdata),
    .WR_I     (wr),
    .RD_I     (rd),
    .RDATA_O  (rdata),
    .SCL_I    (scl_w),
    .SCL_O    (scl_o),
    .SCL_OE_O (scl_oe),
    .SDA_I    (sda_w),
    .SDA_O    (sda_o),
    .SDA_OE_O (sda_oe)
  );

  istx_i2c_master u_mst (
    .scl_o (m_scl),
    .sda_o (m_sda),
    .scl_i (scl_w),
    .sda_i (sda_w)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk(v, e);
  endtask

  // Master sends one byte; e is the acknowledge we expect back
  task automatic xw(input logic [7:0] d, input logic e);
    logic a;
    u_mst.wr(d, a);
    chk({7'h00, a}, {7'h00, e});
  endtask

  task automatic end_sim();
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #3_000_000;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    wr_reg(`ISTX_OFS_CTL, 8'h80);
    u_mst.start();
    xw(8'hF6, 1'b0);
    u_mst.stop();
    u_mst.start();
    xw(8'hF4, 1'b1);
    xw(8'h5D, 1'b0);
    u_mst.stop();
    u_mst.start();
    xw(8'hF5, 1'b0);
    u_mst.stop();
    rd_reg(`ISTX_OFS_ISTAT, rv);
    u_mst.start();
    xw(8'hF4, 1'b1);
    xw(8'h5C, 1'b1);
    rc(`ISTX_OFS_ISTAT, 8'hA0);
    rc(`ISTX_OFS_ISTAT, 8'h80);
    u_mst.start();
    xw(8'hF5, 1'b1);
    rc(`ISTX_OFS_ISTAT, 8'hAA);
    fork
      begin
        u_mst.rd(1'b0, d0);
        u_mst.rd(1'b1, d1);
        u_mst.stop();
      end
      begin
        #3000 chk({7'h00, scl_oe}, 8'h01);
        wr_reg(`ISTX_OFS_DATA, 8'h3C);
        wr_reg(`ISTX_OFS_CTL, 8'hC0);
        #2000 rc(`ISTX_OFS_ISTAT, 8'h88);
        #8000 chk({7'h00, scl_oe}, 8'h01);
        wr_reg(`ISTX_OFS_DATA, 8'hC3);
      end
    join
    chk(d0, 8'h3C);
    chk(d1, 8'hC3);
    rc(`ISTX_OFS_ISTAT, 8'h8B);
    wr_reg(`ISTX_OFS_CTL, 8'h82);
    rc(`ISTX_OFS_ISTAT, 8'h88);
    // Slave receive: data writes must be blocked, received byte lands
    wr_reg(`ISTX_OFS_DATA, 8'h11);
    u_mst.start();
    xw(8'hF4, 1'b1);
    xw(8'h5C, 1'b1);
    rc(`ISTX_OFS_ISTAT, 8'h20);
    wr_reg(`ISTX_OFS_DATA, 8'h77);
    rc(`ISTX_OFS_DATA, 8'h11);
    xw(8'h6A, 1'b1);
    rc(`ISTX_OFS_ISTAT, 8'h40);
    rc(`ISTX_OFS_DATA, 8'h6A);
    rc(`ISTX_OFS_ISTAT, 8'h00);
    u_mst.stop();
    rc(`ISTX_OFS_ISTAT, 8'h02);
    // General call into receive, received byte refused by the NAK bit
    wr_reg(`ISTX_OFS_MODE, 8'h06);
    wr_reg(`ISTX_OFS_CTL, 8'h81);
    u_mst.start();
    xw(8'h00, 1'b1);
    rc(`ISTX_OFS_ISTAT, 8'h30);
    xw(8'h55, 1'b0);
    rc(`ISTX_OFS_ISTAT, 8'h50);
    rc(`ISTX_OFS_DATA, 8'h55);
    u_mst.stop();
    rc(`ISTX_OFS_ISTAT, 8'h12);
    // Reset in mid-run returns every register to its reset value
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    rstn <= 1'b1;
    rc(`ISTX_OFS_ISTAT, 8'h80);
    rc(`ISTX_OFS_CTL, 8'h00);
    rc(`ISTX_OFS_DATA, 8'h00);
    rc(`ISTX_OFS_MODE, 8'h00);
    rc(`ISTX_OFS_SLVAD, 8'h00);
    end_sim();
  end
endmodule // tb_top
